// file: pkg/dcp_consts.svh
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH

// Channel count and index width
`define DCP_CH 32
`define DCP_CHW 5

// Register offsets (byte addresses, one aligned word each)
`define DCP_OFF_STATUS 12'h000
`define DCP_OFF_CTL_BASE 12'h008
`define DCP_OFF_BURST_ONLY_SET 12'h018
`define DCP_OFF_BURST_ONLY_CLEAR 12'h01C
`define DCP_OFF_REQ_MASK_SET 12'h020
`define DCP_OFF_REQUEST_MASK_CLEAR 12'h024
`define DCP_OFF_CHANNEL_ENABLE_SET 12'h028
`define DCP_OFF_CHANNEL_ENABLE_CLEAR 12'h02C
`define DCP_OFF_STRUCT_ALT_SET 12'h030
`define DCP_OFF_STRUCTURE_SELECT_CLEAR 12'h034
`define DCP_OFF_CHANNEL_PRIORITY_SET 12'h038
`define DCP_OFF_CHANNEL_PRIORITY_CLEAR 12'h03C

// Reset value and table base write mask
`define DCP_RST_WORD 32'h0000_0000
`define DCP_CTL_BASE_MASK 32'hFFFF_FC00

// Control table layout
`define DCP_ALT_OFFSET 32'h0000_0200
`define DCP_WORD_SRC_END 32'h0000_0000
`define DCP_WORD_DST_END 32'h0000_0004
`define DCP_WORD_CTL 32'h0000_0008

// Control word fields
`define DCP_DINC_HI 31
`define DCP_DINC_LO 30
`define DCP_DSIZE_HI 29
`define DCP_DSIZE_LO 28
`define DCP_SINC_HI 27
`define DCP_SINC_LO 26
`define DCP_SSIZE_HI 25
`define DCP_SSIZE_LO 24
`define DCP_ARB_HI 17
`define DCP_ARB_LO 14
`define DCP_CNT_HI 13
`define DCP_CNT_LO 4
`define DCP_MODE_HI 2
`define DCP_MODE_LO 0

// Field encodings
`define DCP_INC_NONE 2'h3
`define DCP_MODE_STOP 3'h0
`define DCP_MODE_BASIC 3'h1
`define DCP_MODE_PINGPONG 3'h3
`define DCP_ARB_MAX 4'hA
`define DCP_SIZE_WORD 2'h2

`endif

// file: pkg/dcp_pkg.sv
package dcp_pkg;
`include "dcp_consts.svh"

    typedef enum logic [6:0] {
        DCP_S_IDLE = 7'h01,
        DCP_S_RISSUE = 7'h02,
        DCP_S_RWAIT = 7'h04,
        DCP_S_RCAP = 7'h08,
        DCP_S_WRITE = 7'h10,
        DCP_S_WBACK = 7'h20,
        DCP_S_SPARE = 7'h40
    } dcp_fsm_t;

    typedef enum logic [1:0] {
        DCP_K_SRC = 2'h0,
        DCP_K_DST = 2'h1,
        DCP_K_CTL = 2'h2,
        DCP_K_DATA = 2'h3
    } dcp_kind_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dcp_reg_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [1:0] size;
    } dcp_mem_req_t;

    typedef struct packed {
        dcp_fsm_t fsm;
        dcp_kind_t kind;
        logic [`DCP_CHW-1:0] ch;
        logic burst;
        logic fin;
        logic [31:0] ctl_base;
        logic [31:0] src_end;
        logic [31:0] dst_end;
        logic [31:0] ctl;
        logic [31:0] data;
        logic [9:0] rem;
        logic [10:0] batch;
        logic [`DCP_CH-1:0] en;
        logic [`DCP_CH-1:0] mask;
        logic [`DCP_CH-1:0] bonly;
        logic [`DCP_CH-1:0] alt;
        logic [`DCP_CH-1:0] prio;
        logic [`DCP_CH-1:0] done;
        dcp_mem_req_t mem;
        logic [31:0] rdata;
    } dcp_state_t;
endpackage

// file: rtl/dcp_engine.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// R1: End pointers address the last item, inclusive
// R2: Primary entry at sixteen bytes per channel
// R3: Alternate entry sits 0x200 above primary
// R4: Destination increment 3 fixed, 0 byte step
// R5: Source increment uses the same coding
// R6: Size field 0 means byte items
// R7: Rearbitration count sets items per burst
// R8: Count field is items minus one, all move
// R9: Mode 1 basic, 3 ping-pong, 0 stopped
// R10: Basic end disables channel, writes mode 0
// R11: Enable bit reads one while active
// R12: Basic mode moves data on peripheral request
// R13: Burst moves burst count, single moves one
// R14: Burst-only bit ignores single requests
// R15: Mask clear write lets requests through
// R16: Select clear write chooses primary structure
// R17: Priority set raises, priority clear restores
// R18: Enable set bit n enables channel n
// R19: Ping-pong swaps structure when buffer fills
// R20: Completion pulses peripheral done line
// R21: Peripheral raises single or burst requests
// R22: Ping-pong primary end writes stopped, signals
// R23: Fourth entry word is never read
`include "dcp_consts.svh"
module dcp_engine
    import dcp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire dcp_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    output dcp_mem_req_t mem_req,
    input wire logic [31:0] mem_rdata,
    input wire logic [`DCP_CH-1:0] req_single,
    input wire logic [`DCP_CH-1:0] req_burst,
    output logic [`DCP_CH-1:0] xfer_done
);

    dcp_state_t s_q;
    dcp_state_t s_d;
    logic [`DCP_CH-1:0] elig;
    logic [`DCP_CHW:0] sel;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Lowest ready channel, high-priority group first
    function automatic logic [`DCP_CHW:0] pick(input logic [`DCP_CH-1:0] v,
                                               input logic [`DCP_CH-1:0] hi);
        logic [`DCP_CH-1:0] w;
        logic [`DCP_CHW:0] r;
        w = ((v & hi) != '0) ? (v & hi) : v; // see R17
        r = '0;
        for (int i = `DCP_CH - 1; i >= 0; i--) begin
            if (w[i]) begin
                r = {1'b1, i[`DCP_CHW-1:0]};
            end
        end
        return r;
    endfunction

    // Address of the item that still has rem items after it
    function automatic logic [31:0] item_addr(input logic [31:0] endp,
                                              input logic [1:0] inc,
                                              input logic [9:0] rem);
        logic [31:0] step;
        step = {22'h00_0000, rem} << inc;
        if (inc == `DCP_INC_NONE) begin // see R4 R5
            return endp;
        end
        return endp - step; // see R1 R6
    endfunction

    // Control table word of the active structure
    function automatic logic [31:0] entry_addr(input logic [31:0] base,
                                               input logic alt_sel,
                                               input logic [`DCP_CHW-1:0] ch,
                                               input logic [31:0] word);
        logic [31:0] off;
        off = {23'h00_0000, ch, 4'h0}; // see R2
        if (alt_sel) begin
            off = off + `DCP_ALT_OFFSET; // see R3
        end
        return base + off + word;
    endfunction

    // Items left in a burst, minus one; large fields clamp to the count width
    function automatic logic [10:0] burst_len(input logic [3:0] arb);
        logic [3:0] a;
        a = (arb > `DCP_ARB_MAX) ? `DCP_ARB_MAX : arb;
        return (11'h001 << a) - 11'h001; // see R7
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Request qualification

    always_comb begin
        // Single requests only count while burst-only is clear
        elig = s_q.en & ~s_q.mask & (req_burst | (req_single & ~s_q.bonly)); // see R12 R14 R15
        sel = pick(elig, s_q.prio);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        s_d.done = '0;
        s_d.mem.rd = 1'b0;
        s_d.mem.wr = 1'b0;
        s_d.rdata = '0;

        case (s_q.fsm)
            DCP_S_IDLE: begin
                if (sel[`DCP_CHW]) begin
                    s_d.ch = sel[`DCP_CHW-1:0];
                    s_d.burst = req_burst[sel[`DCP_CHW-1:0]]; // see R13
                    s_d.kind = DCP_K_SRC;
                    s_d.fsm = DCP_S_RISSUE;
                end
            end
            DCP_S_RISSUE: begin
                s_d.mem.rd = 1'b1;
                s_d.mem.size = `DCP_SIZE_WORD;
                // Only three entry words are ever fetched
                case (s_q.kind) // see R23
                    DCP_K_SRC: begin
                        s_d.mem.addr = entry_addr(s_q.ctl_base, s_q.alt[s_q.ch], s_q.ch,
                                                  `DCP_WORD_SRC_END); // see R2 R3
                    end
                    DCP_K_DST: begin
                        s_d.mem.addr = entry_addr(s_q.ctl_base, s_q.alt[s_q.ch], s_q.ch,
                                                  `DCP_WORD_DST_END);
                    end
                    DCP_K_CTL: begin
                        s_d.mem.addr = entry_addr(s_q.ctl_base, s_q.alt[s_q.ch], s_q.ch,
                                                  `DCP_WORD_CTL);
                    end
                    default: begin
                        s_d.mem.addr = item_addr(s_q.src_end,
                                                 s_q.ctl[`DCP_SINC_HI:`DCP_SINC_LO],
                                                 s_q.rem); // see R5
                        s_d.mem.size = s_q.ctl[`DCP_SSIZE_HI:`DCP_SSIZE_LO]; // see R6
                    end
                endcase
                s_d.fsm = DCP_S_RWAIT;
            end
            DCP_S_RWAIT: begin
                // Memory answers in the cycle after the strobe
                s_d.fsm = DCP_S_RCAP;
            end
            DCP_S_RCAP: begin
                case (s_q.kind)
                    DCP_K_SRC: begin
                        s_d.src_end = mem_rdata;
                        s_d.kind = DCP_K_DST;
                        s_d.fsm = DCP_S_RISSUE;
                    end
                    DCP_K_DST: begin
                        s_d.dst_end = mem_rdata;
                        s_d.kind = DCP_K_CTL;
                        s_d.fsm = DCP_S_RISSUE;
                    end
                    DCP_K_CTL: begin
                        s_d.ctl = mem_rdata;
                        s_d.rem = mem_rdata[`DCP_CNT_HI:`DCP_CNT_LO]; // see R8
                        s_d.batch = s_q.burst ? burst_len(mem_rdata[`DCP_ARB_HI:`DCP_ARB_LO])
                                              : 11'h000; // see R13
                        if (mem_rdata[`DCP_MODE_HI:`DCP_MODE_LO] == `DCP_MODE_BASIC ||
                            mem_rdata[`DCP_MODE_HI:`DCP_MODE_LO] == `DCP_MODE_PINGPONG) begin // see R9
                            s_d.kind = DCP_K_DATA;
                            s_d.fsm = DCP_S_RISSUE;
                        end else begin
                            // A stopped or unsupported structure drops the channel
                            s_d.en[s_q.ch] = 1'b0; // see R9
                            s_d.fsm = DCP_S_IDLE;
                        end
                    end
                    default: begin
                        s_d.data = mem_rdata;
                        s_d.fsm = DCP_S_WRITE;
                    end
                endcase
            end
            DCP_S_WRITE: begin
                s_d.mem.wr = 1'b1;
                s_d.mem.addr = item_addr(s_q.dst_end, s_q.ctl[`DCP_DINC_HI:`DCP_DINC_LO],
                                         s_q.rem); // see R4
                s_d.mem.size = s_q.ctl[`DCP_DSIZE_HI:`DCP_DSIZE_LO]; // see R6
                s_d.mem.wdata = s_q.data;
                if (s_q.rem == 10'h000) begin // see R8
                    s_d.fin = 1'b1;
                    s_d.fsm = DCP_S_WBACK;
                end else begin
                    s_d.rem = s_q.rem - 10'h001;
                    if (s_q.batch == 11'h000) begin // see R7 R13
                        s_d.fsm = DCP_S_WBACK;
                    end else begin
                        s_d.batch = s_q.batch - 11'h001;
                        s_d.kind = DCP_K_DATA;
                        s_d.fsm = DCP_S_RISSUE;
                    end
                end
            end
            DCP_S_WBACK: begin
                s_d.mem.wr = 1'b1;
                s_d.mem.size = `DCP_SIZE_WORD;
                s_d.mem.addr = entry_addr(s_q.ctl_base, s_q.alt[s_q.ch], s_q.ch,
                                          `DCP_WORD_CTL);
                s_d.mem.wdata = s_q.ctl;
                s_d.fsm = DCP_S_IDLE;
                if (s_q.fin) begin
                    s_d.fin = 1'b0;
                    s_d.mem.wdata[`DCP_CNT_HI:`DCP_CNT_LO] = 10'h000;
                    s_d.mem.wdata[`DCP_MODE_HI:`DCP_MODE_LO] = `DCP_MODE_STOP; // see R10 R22
                    s_d.done[s_q.ch] = 1'b1; // see R20 R22
                    if (s_q.ctl[`DCP_MODE_HI:`DCP_MODE_LO] == `DCP_MODE_PINGPONG) begin
                        // Channel stays enabled and carries on in the other buffer
                        s_d.alt[s_q.ch] = ~s_q.alt[s_q.ch]; // see R19 R22
                    end else begin
                        s_d.en[s_q.ch] = 1'b0; // see R10 R11
                    end
                end else begin
                    // Partial progress goes back so the next burst resumes there
                    s_d.mem.wdata[`DCP_CNT_HI:`DCP_CNT_LO] = s_q.rem; // see R8
                end
            end
            default: begin
                s_d.fsm = DCP_S_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        // Register writes come last so a software set beats a hardware clear

        if (reg_req.wr) begin
            case (reg_req.addr)
                `DCP_OFF_CTL_BASE: begin
                    s_d.ctl_base = reg_req.wdata & `DCP_CTL_BASE_MASK;
                end
                `DCP_OFF_BURST_ONLY_SET: begin
                    s_d.bonly = s_d.bonly | reg_req.wdata; // see R14
                end
                `DCP_OFF_BURST_ONLY_CLEAR: begin
                    s_d.bonly = s_d.bonly & ~reg_req.wdata; // see R14
                end
                `DCP_OFF_REQ_MASK_SET: begin
                    s_d.mask = s_d.mask | reg_req.wdata;
                end
                `DCP_OFF_REQUEST_MASK_CLEAR: begin
                    s_d.mask = s_d.mask & ~reg_req.wdata; // see R15
                end
                `DCP_OFF_CHANNEL_ENABLE_SET: begin
                    s_d.en = s_d.en | reg_req.wdata; // see R18
                end
                `DCP_OFF_CHANNEL_ENABLE_CLEAR: begin
                    s_d.en = s_d.en & ~reg_req.wdata;
                end
                `DCP_OFF_STRUCT_ALT_SET: begin
                    s_d.alt = s_d.alt | reg_req.wdata;
                end
                `DCP_OFF_STRUCTURE_SELECT_CLEAR: begin
                    s_d.alt = s_d.alt & ~reg_req.wdata; // see R16
                end
                `DCP_OFF_CHANNEL_PRIORITY_SET: begin
                    s_d.prio = s_d.prio | reg_req.wdata; // see R17
                end
                `DCP_OFF_CHANNEL_PRIORITY_CLEAR: begin
                    s_d.prio = s_d.prio & ~reg_req.wdata; // see R17
                end
                default: begin
                end
            endcase
        end

        if (reg_req.rd) begin
            case (reg_req.addr)
                `DCP_OFF_STATUS: begin
                    s_d.rdata = {19'h0_0000, s_q.ch, 7'h00, (s_q.fsm != DCP_S_IDLE)};
                end
                `DCP_OFF_CTL_BASE: s_d.rdata = s_q.ctl_base;
                `DCP_OFF_BURST_ONLY_SET: s_d.rdata = s_q.bonly;
                `DCP_OFF_REQ_MASK_SET: s_d.rdata = s_q.mask;
                `DCP_OFF_CHANNEL_ENABLE_SET: s_d.rdata = s_q.en; // see R11
                `DCP_OFF_STRUCT_ALT_SET: s_d.rdata = s_q.alt;
                `DCP_OFF_CHANNEL_PRIORITY_SET: s_d.rdata = s_q.prio;
                default: s_d.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.fsm <= DCP_S_IDLE;
            s_q.kind <= DCP_K_SRC;
            s_q.ctl_base <= `DCP_RST_WORD;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign mem_req = s_q.mem;
    assign xfer_done = s_q.done;

endmodule

// file: bench/dcp_mem_model.sv
`timescale 1ns/1ps
module dcp_mem_model
    import dcp_pkg::*;
(
    input wire logic mclk,
    input wire dcp_mem_req_t mem_req,
    output logic [31:0] mem_rdata
);
    // Sparse word store keyed by byte address; byte lanes are not modelled
    logic [31:0] mem [logic [31:0]];
    logic [31:0] last_q = 32'h0000_0000;
    logic vld_q = 1'b0;
    // Outside the answer cycle the bus shows the inverse, so stale data never looks valid
    assign mem_rdata = vld_q ? last_q : ~last_q;
    always @(posedge mclk) begin
        vld_q <= mem_req.rd;
        if (mem_req.rd)
            last_q <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : ~mem_req.addr;
        if (mem_req.wr)
            mem[mem_req.addr] = mem_req.wdata;
    end
endmodule

// file: bench/dcp_engine_checker.sv
`timescale 1ns/1ps
`include "dcp_consts.svh"
module dcp_engine_checker
    import dcp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire dcp_reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input wire dcp_mem_req_t mem_req,
    input wire logic [31:0] mem_rdata,
    input wire logic [`DCP_CH-1:0] req_single,
    input wire logic [`DCP_CH-1:0] req_burst,
    input wire logic [`DCP_CH-1:0] xfer_done
);
    logic [31:0] base_q;
    logic [4:0] done_ch;
    ////////////////////////////////////////////////////////////
    // Table base is shadowed from bus writes so table reads can be told apart
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            base_q <= 32'h0000_0000;
        else if (reg_req.wr && reg_req.addr == `DCP_OFF_CTL_BASE)
            base_q <= reg_req.wdata & `DCP_CTL_BASE_MASK;
    end
    always_comb begin
        done_ch = 5'h00;
        for (int i = 0; i < `DCP_CH; i++) begin
            if (xfer_done[i])
                done_ch = i[4:0];
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_entry_start;
        mem_req.rd && mem_req.addr[31:10] == base_q[31:10] && mem_req.addr[3:0] == 4'h0;
    endsequence
    sequence s_entry_rest;
        ##3 mem_req.rd && mem_req.addr == $past(mem_req.addr, 3) + 32'h0000_0004
        ##3 mem_req.rd && mem_req.addr == $past(mem_req.addr, 6) + 32'h0000_0008;
    endsequence
    a_fetch_order: assert property (s_entry_start |-> s_entry_rest)
        else $error("entry words not fetched in order");
    a_no_fourth: assert property (
        mem_req.rd && mem_req.addr[31:10] == base_q[31:10] |-> mem_req.addr[3:0] != 4'hC)
        else $error("unused entry word read");
    a_req_cause: assert property (s_entry_start |-> $past(req_single | req_burst, 2) != '0)
        else $error("service without a request");
    a_rd_gap: assert property (mem_req.rd |=> (!mem_req.rd && !mem_req.wr) [*2])
        else $error("memory read not followed by two idle cycles");
    a_done_pulse: assert property (xfer_done != '0 |-> $onehot(xfer_done) ##1 xfer_done == '0)
        else $error("completion not a single one-cycle pulse");
    a_done_wb: assert property (xfer_done != '0 |-> mem_req.wr
        && mem_req.wdata[2:0] == `DCP_MODE_STOP && mem_req.addr[8:0] == {done_ch, 4'h8}
        && mem_req.addr[31:10] == base_q[31:10])
        else $error("completion without stopped control word write");
    a_rdata_quiet: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    a_quiet_reset: assert property ($past(reset) |-> !mem_req.rd && !mem_req.wr
        && xfer_done == '0)
        else $error("activity on first edge after reset");
endmodule
bind dcp_engine dcp_engine_checker chk_i (.mclk(mclk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .req_single(req_single), .req_burst(req_burst), .xfer_done(xfer_done));

// file: bench/dcp_engine_tb.sv
`timescale 1ns/1ps
`include "dcp_consts.svh"
module dcp_engine_tb
    import dcp_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    dcp_reg_req_t reg_req = '0;
    dcp_mem_req_t mem_req;
    logic [31:0] reg_rdata, mem_rdata, xfer_done, v;
    logic [`DCP_CH-1:0] req_single = '0;
    logic [`DCP_CH-1:0] req_burst = '0;
    logic [63:0] e;
    logic [63:0] exp_q [$];
    logic [11:0] offs [7] = '{12'h018, 12'h020, 12'h028, 12'h030, 12'h038, 12'h01C, 12'h100};
    integer seed = 32'h674c_1119;
    int miscompares = 0, total_checks = 0, cyc = 0, rd_cnt = 0, ctl_cnt = 0;
    int items = 0, last_items = 0, d7 = 0, d8 = 0;
    always #5 mclk = ~mclk;
    dcp_engine dut (.mclk(mclk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .req_single(req_single),
        .req_burst(req_burst), .xfer_done(xfer_done));
    dcp_mem_model mem_i (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        @(negedge mclk);
        chk(n, reg_rdata, x);
    endtask
    // Request held until the first table read; the engine latches it at pick time
    task automatic ask(input int ch, input bit burst, input int n);
        int r0;
        int c0;
        r0 = rd_cnt;
        c0 = ctl_cnt;
        @(posedge mclk);
        if (burst)
            req_burst[ch] <= 1'b1;
        else
            req_single[ch] <= 1'b1;
        if (n == 0) begin
            repeat (30) @(posedge mclk);
            chk("refused request", rd_cnt - r0, 0);
        end else begin
            for (int k = 0; k < 20 && rd_cnt == r0; k++) @(negedge mclk);
        end
        @(posedge mclk);
        req_single[ch] <= 1'b0;
        req_burst[ch] <= 1'b0;
        if (n > 0) begin
            for (int k = 0; k < 300 && ctl_cnt == c0; k++) @(negedge mclk);
            chk("items per service", last_items, n);
            chk("control write back", ctl_cnt - c0, 1);
        end
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish();
        end
        if (!reset && mem_req.rd)
            rd_cnt++;
        if (xfer_done[7] === 1'b1)
            d7++;
        if (xfer_done[8] === 1'b1)
            d8++;
        if (!reset && mem_req.wr) begin
            if (mem_req.addr[31:12] == 20'h0_0001) begin
                ctl_cnt++;
                last_items = items;
                items = 0;
            end else begin
                items++;
                e = exp_q.size() > 0 ? exp_q.pop_front() : 64'h0;
                chk("dest addr", mem_req.addr, e[63:32]);
                chk("dest data", mem_req.wdata, e[31:0]);
                chk("dest size", mem_req.size, 0);
            end
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) rd(offs[i], 32'h0000_0000, "reset value");
        wr(`DCP_OFF_CTL_BASE, 32'h0000_13FF);
        rd(`DCP_OFF_CTL_BASE, 32'h0000_1000, "table base");
        wr(`DCP_OFF_CHANNEL_PRIORITY_SET, 32'h0000_0080);
        rd(`DCP_OFF_CHANNEL_PRIORITY_SET, 32'h0000_0080, "prio set");
        wr(`DCP_OFF_CHANNEL_PRIORITY_CLEAR, 32'h0000_0080);
        rd(`DCP_OFF_CHANNEL_PRIORITY_SET, 32'h0000_0000, "prio clear");
        wr(`DCP_OFF_STRUCT_ALT_SET, 32'h0000_0100);
        wr(`DCP_OFF_STRUCTURE_SELECT_CLEAR, 32'h0000_0180);
        rd(`DCP_OFF_STRUCT_ALT_SET, 32'h0000_0000, "alt clear");
        // Byte transmit: source steps, destination fixed, 64 items, 4 per burst
        mem_i.mem[32'h0000_1070] = 32'h0000_403F;
        mem_i.mem[32'h0000_1074] = 32'h0000_5000;
        mem_i.mem[32'h0000_1078] = 32'hC000_83F1;
        for (int i = 0; i < 64; i++) begin
            v = $random(seed);
            mem_i.mem[32'h0000_4000 + i] = v;
            exp_q.push_back({32'h0000_5000, v});
        end
        wr(`DCP_OFF_CHANNEL_ENABLE_SET, 32'h0000_0080);
        rd(`DCP_OFF_CHANNEL_ENABLE_SET, 32'h0000_0080, "enable");
        wr(`DCP_OFF_REQ_MASK_SET, 32'h0000_0080);
        ask(7, 0, 0);
        wr(`DCP_OFF_REQUEST_MASK_CLEAR, 32'h0000_0080);
        rd(`DCP_OFF_REQ_MASK_SET, 32'h0000_0000, "mask clear");
        wr(`DCP_OFF_BURST_ONLY_SET, 32'h0000_0080);
        ask(7, 0, 0);
        ask(7, 1, 4);
        wr(`DCP_OFF_BURST_ONLY_CLEAR, 32'h0000_0080);
        repeat (4) ask(7, 0, 1);
        repeat (14) ask(7, 1, 4);
        chk("done count 7", d7, 1);
        chk("basic mode field", mem_i.mem[32'h0000_1078][2:0], 0);
        rd(`DCP_OFF_CHANNEL_ENABLE_SET, 32'h0000_0000, "enable after end");
        // Ping-pong receive: fixed source, two 16-item buffers, 8 per burst
        mem_i.mem[32'h0000_1080] = 32'h0000_6000;
        mem_i.mem[32'h0000_1084] = 32'h0000_703F;
        mem_i.mem[32'h0000_1088] = 32'h0C00_C0F3;
        mem_i.mem[32'h0000_1280] = 32'h0000_6000;
        mem_i.mem[32'h0000_1284] = 32'h0000_713F;
        mem_i.mem[32'h0000_1288] = 32'h0C00_C0F3;
        wr(`DCP_OFF_CHANNEL_ENABLE_SET, 32'h0000_0100);
        for (int b = 0; b < 4; b++) begin
            v = $random(seed);
            mem_i.mem[32'h0000_6000] = v;
            for (int j = 0; j < 8; j++)
                exp_q.push_back({(b < 2 ? 32'h0000_7030 : 32'h0000_7130) + (b % 2) * 8 + j, v});
            ask(8, 1, 8);
            if (b == 1) begin
                chk("primary mode field", mem_i.mem[32'h0000_1088][2:0], 0);
                chk("done count 8", d8, 1);
                rd(`DCP_OFF_STRUCT_ALT_SET, 32'h0000_0100, "swap to alternate");
            end
        end
        // Primary now reads stopped, so the next request only drops the channel
        @(posedge mclk);
        req_burst[8] <= 1'b1;
        repeat (20) @(posedge mclk);
        req_burst[8] <= 1'b0;
        rd(`DCP_OFF_CHANNEL_ENABLE_SET, 32'h0000_0000, "stopped entry");
        chk("done count 8", d8, 2);
        chk("items left", exp_q.size(), 0);
        tally_and_finish();
    end
endmodule
